// ### rtl/ssvc_pkg.sv
// Shared constants for the supply voltage supervisor control block
package ssvc_pkg;
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] OFF_LEVEL = 8'h00;
  localparam logic [7:0] OFF_SAMPLING = 8'h04;
  localparam logic [7:0] OFF_MODE = 8'h08;
  localparam logic [7:0] OFF_CONTROL = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  // Field positions
  localparam int LEVEL_LSB = 0;
  localparam int LEVEL_W = 4;
  localparam int SMP_SRC_BIT = 3;
  localparam int SMP_DIV_LSB = 4;
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_AMD_LSB = 2;
  localparam int CTL_EN_BIT = 0;
  localparam int STS_LVF_BIT = 0;
  localparam int STS_RF_BIT = 1;

  // Reset values and encodings
  localparam logic [3:0] LEVEL_RESET = 4'h0;
  localparam logic [1:0] SEL_RESET = 2'h1;
  localparam logic [1:0] SEL_IRQ = 2'h2;
  localparam logic [1:0] AMD_SUPER_A = 2'h2;
  localparam logic [1:0] AMD_SUPER_B = 2'h3;

  // Timing: stabilisation in us, low-speed clock in Hz, waits in low-speed clock cycles, filter depth in samples
  localparam int STAB_TIME_US = 300;
  localparam int LS_CLK_HZ = 32768;
  localparam int STAB_LS_CYCLES = (STAB_TIME_US * LS_CLK_HZ + 999999) / 1000000;
  localparam int HOLD_LS_CYCLES = 512;
  localparam int FILTER_DEPTH = 3;
endpackage

// ### rtl/ssvc_sync2.sv
// Two-flop synchroniser for the asynchronous comparator output
`timescale 1ns/1ps
module ssvc_sync2 (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Level in and out
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic first;
    logic second;
  } ssvc_sync_t;

  ssvc_sync_t s;
  ssvc_sync_t next_s;

  // First stage is read only by the second stage
  always_comb begin
    next_s = s;
    next_s.first = din;
    next_s.second = s.first;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign dout = s.second;
endmodule

// ### rtl/ssvc_filter.sv
// Sampling divider and consecutive-sample filter for the comparator level
`timescale 1ns/1ps
module ssvc_filter #(
  parameter int DEPTH = ssvc_pkg::FILTER_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Control
  input wire logic clear,
  input wire logic ls_tick,
  input wire logic [1:0] div,
  // Level in, filtered level out
  input wire logic din,
  output logic dout,
  output logic primed
);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [2:0] div_cnt;
    logic [DEPTH-1:0] hist;
    logic [CW-1:0] cnt;
    logic out;
  } ssvc_filt_t;

  ssvc_filt_t s;
  ssvc_filt_t next_s;
  logic [2:0] limit;
  logic sample;

  // Divide ratio 1, 2, 4 or 8 low-speed cycles per sample
  always_comb begin
    case (div)
      2'h0: limit = 3'h0;
      2'h1: limit = 3'h1;
      2'h2: limit = 3'h3;
      default: limit = 3'h7;
    endcase
    sample = ls_tick && (s.div_cnt == limit);
  end

  // No low-speed edge, no sample: a stopped clock freezes the output
  always_comb begin
    next_s = s;
    if (clear) begin
      next_s = '0;
    end else begin
      if (ls_tick) begin
        next_s.div_cnt = sample ? 3'h0 : 3'(s.div_cnt + 3'h1);
      end
      if (sample) begin
        next_s.hist = {s.hist[DEPTH-2:0], din};
        if (s.cnt != CW'(DEPTH)) begin
          next_s.cnt = CW'(s.cnt + 1'b1);
        end
        // Change only after DEPTH equal samples in a row
        if (&next_s.hist) begin
          next_s.out = 1'b1;
        end else if (~|next_s.hist) begin
          next_s.out = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign dout = s.out;
  assign primed = (s.cnt == CW'(DEPTH));
endmodule

// ### rtl/ssvc_top.sv
// Supply voltage supervisor control: stabilisation, filtering, flags, reset and interrupt
//
// What this block does
// - Supervisor mode runs when the operating mode field is 0x2 or 0x3.
// - Output select 0x1 routes low-voltage detection to system reset.
// - Output select 0x2 routes detection events to the interrupt instead.
// - Writing enable one starts monitoring; it continues until software clears it.
// - Without sampling, result-valid sets after about 300 us stabilisation.
// - Low-voltage flag, interrupt and reset are masked until result-valid is one.
// - Unsampled reset mode: supply below falling threshold sets flag and reset.
// - Reset mode: supply at or above rising threshold clears flag, releases reset.
// - After monitor reset releases, hold the processor 512 low-speed cycles.
// - With sampling, result-valid sets three sample cycles after stabilisation.
// - With sampling, flag sets only after three consecutive below samples.
// - Sampled interrupt mode: three consecutive above samples clear flag, interrupt.
// - Unsampled interrupt mode: falling below threshold sets flag and interrupts.
// - Unsampled interrupt mode: rising back clears flag and also interrupts.
// - With sampling and a stopped sampling clock, flags and outputs hold.
// - Writing enable zero stops monitoring.
// - Disabling while the low-voltage flag is one raises an interrupt when output select is 0x2.
// - Sampling source bit: zero no sampling (reset value), one low-speed clock.
// - In stop and deep-stop states, run without sampling regardless of source.
`timescale 1ns/1ps
module ssvc_top (
  // Clock, reset, clock enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Analog side and system state
  input wire logic cmp_below,
  input wire logic low_speed_clock_zero,
  input wire logic stop_mode,
  output logic [3:0] detect_level,
  output logic cmp_enable,
  // System outputs
  output logic monitor_reset,
  output logic cpu_hold,
  output logic irq
);
  localparam int HOLD_W = $clog2(ssvc_pkg::HOLD_LS_CYCLES + 1);
  localparam int STAB_W = $clog2(ssvc_pkg::STAB_LS_CYCLES + 1);
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(ssvc_pkg::HOLD_LS_CYCLES);
  localparam logic [STAB_W-1:0] STAB_LAST = STAB_W'(ssvc_pkg::STAB_LS_CYCLES - 1);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STABLE = 2'b01,
    ST_SAMPLE = 2'b10,
    ST_ACTIVE = 2'b11
  } ssvc_state_t;

  typedef struct packed {
    logic [3:0] level;
    logic smp_src;
    logic [1:0] smp_div;
    logic [1:0] amd;
    logic [1:0] sel;
    logic en;
    logic rf;
    logic lvf;
    ssvc_state_t state;
    logic [STAB_W-1:0] stab_cnt;
    logic [HOLD_W-1:0] hold_cnt;
    logic ls_d;
    logic rst_out;
    logic irq;
    logic [31:0] rdata;
  } ssvc_regs_t;

  // Detection level comes up at its documented default code
  localparam ssvc_regs_t RESET_STATE = '{
    level: ssvc_pkg::LEVEL_RESET,
    state: ST_IDLE,
    default: '0
  };

  ssvc_regs_t s;
  ssvc_regs_t next_s;

  logic cmp_sync;
  logic filt_out;
  logic filt_primed;
  logic filt_clear;
  logic ls_tick;
  logic sampling;
  logic supervisor;
  logic run;
  logic src_level;
  logic irq_route;
  logic rst_route;

  // Comparator into the clock domain before anything looks at it
  ssvc_sync2 u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .din(cmp_below),
    .dout(cmp_sync)
  );

  // Filter only runs once stabilisation has elapsed
  assign filt_clear = (s.state == ST_IDLE) || (s.state == ST_STABLE) || !sampling;

  ssvc_filter #(
    .DEPTH(ssvc_pkg::FILTER_DEPTH)
  ) u_filter (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .clear(filt_clear),
    .ls_tick(ls_tick),
    .div(s.smp_div),
    .din(cmp_sync),
    .dout(filt_out),
    .primed(filt_primed)
  );

  // Decoded modes
  always_comb begin
    ls_tick = low_speed_clock_zero && !s.ls_d;
    sampling = s.smp_src && !stop_mode;
    supervisor = (s.amd == ssvc_pkg::AMD_SUPER_A)
      || (s.amd == ssvc_pkg::AMD_SUPER_B);
    run = s.en && supervisor;
    // A freshly cleared filter reads low; keep the flag until three samples are in
    src_level = sampling ? (filt_primed ? filt_out : s.lvf) : cmp_sync;
    irq_route = (s.sel == ssvc_pkg::SEL_IRQ);
    rst_route = (s.sel == ssvc_pkg::SEL_RESET);
  end

  // Next state of the whole block
  always_comb begin
    next_s = s;
    next_s.irq = 1'b0;
    next_s.rdata = '0;
    next_s.ls_d = low_speed_clock_zero;

    // Low-speed hold counter after a monitor reset goes away
    if (ls_tick && s.hold_cnt != '0) begin
      next_s.hold_cnt = HOLD_W'(s.hold_cnt - 1'b1);
    end

    // Register writes
    if (wr) begin
      case (addr)
        ssvc_pkg::OFF_LEVEL: begin
          next_s.level = wdata[ssvc_pkg::LEVEL_LSB +: ssvc_pkg::LEVEL_W];
        end
        ssvc_pkg::OFF_SAMPLING: begin
          next_s.smp_src = wdata[ssvc_pkg::SMP_SRC_BIT];
          next_s.smp_div = wdata[ssvc_pkg::SMP_DIV_LSB +: 2];
        end
        ssvc_pkg::OFF_MODE: begin
          next_s.sel = wdata[ssvc_pkg::MODE_SEL_LSB +: 2];
          next_s.amd = wdata[ssvc_pkg::MODE_AMD_LSB +: 2];
        end
        ssvc_pkg::OFF_CONTROL: begin
          next_s.en = wdata[ssvc_pkg::CTL_EN_BIT];
        end
        default: begin
        end
      endcase
    end

    // Monitoring sequence
    case (s.state)
      ST_IDLE: begin
        next_s.rf = 1'b0;
        next_s.lvf = 1'b0;
        next_s.stab_cnt = '0;
        if (run) begin
          next_s.state = ST_STABLE;
        end
      end
      ST_STABLE: begin
        // Counted on the low-speed clock so the wait is rate independent
        if (ls_tick) begin
          if (s.stab_cnt == STAB_LAST) begin
            if (sampling) begin
              next_s.state = ST_SAMPLE;
            end else begin
              next_s.state = ST_ACTIVE;
              next_s.rf = 1'b1;
              next_s.lvf = cmp_sync;
              next_s.irq = cmp_sync && irq_route;
            end
          end else begin
            next_s.stab_cnt = STAB_W'(s.stab_cnt + 1'b1);
          end
        end
      end
      ST_SAMPLE: begin
        // Three samples must be in before the result counts
        if (!sampling) begin
          next_s.state = ST_ACTIVE;
          next_s.rf = 1'b1;
          next_s.lvf = cmp_sync;
          next_s.irq = cmp_sync && irq_route;
        end else if (filt_primed) begin
          next_s.state = ST_ACTIVE;
          next_s.rf = 1'b1;
          next_s.lvf = filt_out;
          next_s.irq = filt_out && irq_route;
        end
      end
      ST_ACTIVE: begin
        // Filtered source holds still while the sampling clock stops
        if (src_level != s.lvf) begin
          next_s.lvf = src_level;
          // Both edges interrupt when routed to the interrupt
          next_s.irq = irq_route;
        end
      end
      default: begin
        next_s.state = ST_IDLE;
      end
    endcase

    // Stop: flag one at disable raises one last interrupt if routed to the interrupt, then clears
    if (!run && s.state != ST_IDLE) begin
      next_s.state = ST_IDLE;
      next_s.rf = 1'b0;
      next_s.lvf = 1'b0;
      next_s.irq = s.lvf && irq_route;
    end

    // Reset output only once the result is valid
    next_s.rst_out = next_s.rf && next_s.lvf && rst_route;

    // Every release of the reset starts the hold, a disable included
    if (s.rst_out && !next_s.rst_out) begin
      next_s.hold_cnt = HOLD_LOAD;
    end

    // Read data stands only in the cycle after the strobe
    if (rd) begin
      case (addr)
        ssvc_pkg::OFF_LEVEL: begin
          next_s.rdata[ssvc_pkg::LEVEL_LSB +: ssvc_pkg::LEVEL_W] = s.level;
        end
        ssvc_pkg::OFF_SAMPLING: begin
          next_s.rdata[ssvc_pkg::SMP_SRC_BIT] = s.smp_src;
          next_s.rdata[ssvc_pkg::SMP_DIV_LSB +: 2] = s.smp_div;
        end
        ssvc_pkg::OFF_MODE: begin
          next_s.rdata[ssvc_pkg::MODE_SEL_LSB +: 2] = s.sel;
          next_s.rdata[ssvc_pkg::MODE_AMD_LSB +: 2] = s.amd;
        end
        ssvc_pkg::OFF_CONTROL: begin
          next_s.rdata[ssvc_pkg::CTL_EN_BIT] = s.en;
        end
        ssvc_pkg::OFF_STATUS: begin
          next_s.rdata[ssvc_pkg::STS_RF_BIT] = s.rf;
          next_s.rdata[ssvc_pkg::STS_LVF_BIT] = s.lvf && s.rf;
        end
        default: begin
          next_s.rdata = '0; // Unmapped reads zero
        end
      endcase
    end
  end

  // One register bank; clock enable low freezes every bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= RESET_STATE;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // Outputs
  assign rdata = s.rdata;
  assign detect_level = s.level;
  assign cmp_enable = s.en;
  assign monitor_reset = s.rst_out;
  assign cpu_hold = s.rst_out || (s.hold_cnt != '0);
  assign irq = s.irq;
endmodule

// ### verification/ssvc_checker.sv
// Port assertions for the supervisor control block
`timescale 1ns/1ps
module ssvc_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Register writes
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  // Monitor side
  input wire logic cmp_below,
  input wire logic low_speed_clock_zero,
  input wire logic cmp_enable,
  input wire logic monitor_reset,
  input wire logic cpu_hold,
  input wire logic irq
);
  logic ls_q;
  logic [9:0] hold_ls;
  // LS edges counted while the hold outlives the reset; slack of two for edge alignment
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ls_q <= 1'b0;
      hold_ls <= 10'h000;
    end else begin
      ls_q <= low_speed_clock_zero;
      if (monitor_reset || !cpu_hold)
        hold_ls <= 10'h000;
      else if (low_speed_clock_zero && !ls_q && hold_ls != 10'h3ff)
        hold_ls <= hold_ls + 10'h001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_ctl_wr;
    wr && clk_en && addr == ssvc_pkg::OFF_CONTROL;
  endsequence
  sequence s_off;
    !cmp_enable [*3];
  endsequence
  property p_en_write;
    s_ctl_wr |=> cmp_enable == $past(wdata[0]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable bit not taken");
  property p_off_quiet;
    s_off |-> !monitor_reset;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("reset while disabled");
  property p_reset_hold;
    monitor_reset |-> cpu_hold;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("cpu runs in reset");
  property p_hold_min;
    $fell(cpu_hold) |-> hold_ls >= 10'd511;
  endproperty
  a_hold_min: assert property (p_hold_min) else $error("hold too short");
  property p_hold_max;
    hold_ls <= 10'd514;
  endproperty
  a_hold_max: assert property (p_hold_max) else $error("hold too long");
  property p_irq_pulse;
    irq |=> !irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
  property p_irq_excl;
    monitor_reset |-> !irq;
  endproperty
  a_irq_excl: assert property (p_irq_excl) else $error("irq beside reset");
  property p_reset_cause;
    $rose(monitor_reset) |-> $past(cmp_below, 3);
  endproperty
  a_reset_cause: assert property (p_reset_cause) else $error("reset without low supply");
endmodule

bind ssvc_top ssvc_checker i_ssvc_checker (.clk, .reset_n, .clk_en, .addr, .wdata, .wr,
  .cmp_below, .low_speed_clock_zero, .cmp_enable, .monitor_reset, .cpu_hold, .irq);

// ### verification/ssvc_partner.sv
// Partner model: supply comparator and low-speed clock source
`timescale 1ns/1ps
module ssvc_partner (
  // Bench controls
  input wire logic run,
  input wire logic below,
  // Toward the block
  output logic ls_clk,
  output wire logic cmp_out
);
  // 800 ns LS clock, parked low while stopped, offset from the system clock
  initial begin
    ls_clk = 1'b0;
    #10;
    forever #400 ls_clk = run ? !ls_clk : 1'b0;
  end
  // Comparator settles a while after the supply moves
  assign #130 cmp_out = below;
endmodule

// ### verification/ssvc_tb_top.sv
// Self-checking bench for the supply voltage supervisor control block
`timescale 1ns/1ps
module ssvc_tb_top;
  logic clk, reset_n, clk_en, wr, rd, stop_mode, run, below, cmp_below, ls_clk;
  logic cmp_enable, monitor_reset, cpu_hold, irq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0] detect_level, lv;
  int n_errors, compares, n_irq, exp_irq;
  ssvc_top i_ssvc_top (.clk, .reset_n, .clk_en, .addr, .wdata, .wr, .rd, .rdata, .cmp_below,
    .low_speed_clock_zero(ls_clk), .stop_mode, .detect_level, .cmp_enable, .monitor_reset,
    .cpu_hold, .irq);
  ssvc_partner i_ssvc_partner (.run, .below, .ls_clk, .cmp_out(cmp_below));
  // 10 MHz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Interrupt pulses seen
  always @(posedge clk) begin
    if (irq === 1'b1) n_irq++;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", e, rdata);
    @(posedge clk); // Later stimulus lands on a rising edge
  endtask
  task automatic st(input logic [1:0] e);
    rd_chk(ssvc_pkg::OFF_STATUS, {30'h0, e});
  endtask
  // Waits whole LS cycles, then lets the flags settle
  task automatic ls(input int n);
    repeat (n) @(posedge ls_clk);
    repeat (3) @(posedge clk);
  endtask
  task automatic cfg(input logic [31:0] smp, input logic [31:0] mode);
    wr_reg(ssvc_pkg::OFF_SAMPLING, smp);
    wr_reg(ssvc_pkg::OFF_MODE, mode);
    wr_reg(ssvc_pkg::OFF_CONTROL, 32'h1);
  endtask
  task automatic off;
    wr_reg(ssvc_pkg::OFF_CONTROL, 32'h0);
  endtask
  task automatic end_of_test;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Hang guard, several times the expected run
  initial begin
    #3000000;
    n_errors++;
    end_of_test();
  end
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    stop_mode = 1'b0;
    run = 1'b1;
    below = 1'b0;
    void'($urandom(36));
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd_chk(8'(4 * i), 32'h0);
    chk("pins", 32'h0, {24'h0, cpu_hold, monitor_reset, irq, cmp_enable, detect_level});
    lv = 4'($urandom);
    wr_reg(8'h00, {28'h0, lv});
    wr_reg(8'h10, 32'h3);
    wr_reg(8'h14, 32'hf);
    rd_chk(8'h00, {28'h0, lv});
    chk("level", {28'h0, lv}, {28'h0, detect_level});
    st(2'h0);
    // Clock enable low: the strobe must be ignored
    clk_en <= 1'b0;
    wr_reg(ssvc_pkg::OFF_LEVEL, {28'h0, ~lv});
    clk_en <= 1'b1;
    rd_chk(ssvc_pkg::OFF_LEVEL, {28'h0, lv});
    $display("test registers done");
    // Every operating mode with low supply; only 2 and 3 supervise
    for (int m = 0; m < 4; m++) begin
      below <= 1'b1;
      cfg(32'h0, 32'(4 * m + 2));
      ls(5);
      st(2'h0);
      ls(8);
      st(m > 1 ? 2'h3 : 2'h0);
      if (m > 1) exp_irq += 2;
      off();
      below <= 1'b0;
      ls(1);
      st(2'h0);
      chk("irqs", exp_irq, n_irq);
    end
    $display("test modes done");
    cfg(32'h0, 32'h9);
    ls(12);
    below <= 1'b1;
    repeat (8) @(posedge clk);
    st(2'h3);
    chk("reset", 32'h3, {30'h0, monitor_reset, cpu_hold});
    below <= 1'b0;
    repeat (8) @(posedge clk);
    st(2'h2);
    chk("reset", 32'h1, {30'h0, monitor_reset, cpu_hold});
    ls(505);
    chk("hold", 32'h1, {31'h0, cpu_hold});
    ls(10);
    chk("hold", 32'h0, {31'h0, cpu_hold});
    chk("irqs", exp_irq, n_irq);
    off();
    $display("test reset output done");
    cfg(32'h0, 32'he);
    ls(12);
    below <= 1'b1;
    repeat (8) @(posedge clk);
    st(2'h3);
    below <= 1'b0;
    repeat (8) @(posedge clk);
    st(2'h2);
    exp_irq += 2;
    chk("irqs", exp_irq, n_irq);
    off();
    $display("test interrupt output done");
    // Sampled, one LS cycle per sample
    cfg(32'h8, 32'he);
    ls(11);
    st(2'h0);
    ls(4);
    st(2'h2);
    below <= 1'b1;
    ls(2);
    below <= 1'b0;
    ls(3);
    st(2'h2);
    below <= 1'b1;
    ls(4);
    st(2'h3);
    run <= 1'b0;
    below <= 1'b0;
    repeat (60) @(posedge clk);
    st(2'h3);
    stop_mode <= 1'b1;
    repeat (8) @(posedge clk);
    st(2'h2);
    stop_mode <= 1'b0;
    run <= 1'b1;
    below <= 1'b1;
    ls(5);
    st(2'h3);
    below <= 1'b0;
    ls(2);
    st(2'h3);
    ls(3);
    st(2'h2);
    exp_irq += 4;
    off();
    ls(1);
    chk("irqs", exp_irq, n_irq);
    $display("test sampling done");
    end_of_test();
  end
endmodule
